// ===== rtl/srl_pkg.sv
// Constants, register map and carrier types for the speed reference limiter
package srl_pkg;
  // Timing at a 100 MHz clock
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned OVS_TIME_MS = 20;
  localparam int unsigned OVS_CYCLES  = OVS_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned EP_STEP_US  = 1000;
  localparam int unsigned EP_CYCLES   = EP_STEP_US * (CLK_HZ / 1_000_000);
  localparam int          OVS_CNT_W   = 21;
  localparam int          EP_CNT_W    = 17;

  // Scales; all speeds are unsigned or signed 0.1 Hz steps
  localparam logic [15:0] FULL_SCALE = 16'h1388;
  localparam logic [6:0]  MARGIN_OFF = 7'h64;
  localparam logic [22:0] PCT_DIV    = 23'h000064;
  localparam int          NET_SHIFT  = 13;

  // Reset values
  localparam logic [15:0] MIN_RST    = 16'h001E;
  localparam logic [15:0] MAX_RST    = 16'h0294;
  localparam logic [6:0]  MARGIN_RST = 7'h0A;
  localparam logic [1:0]  BACKUP_RST = 2'h1;
  localparam logic [15:0] KEY_RST    = 16'h001E;
  localparam logic [15:0] JOG_RST    = 16'h0032;
  localparam logic [15:0] RATED_RST  = 16'h0258;
  localparam logic [7:0][15:0] PRESET_RST = {16'h0294, 16'h0258, 16'h01F4, 16'h0190,
                                             16'h012C, 16'h00C8, 16'h0064, 16'h001E};

  // Reference source selector codes
  localparam logic [3:0] SRC_KEYPAD = 4'h0;
  localparam logic [3:0] SRC_EP     = 4'h7;
  localparam logic [3:0] SRC_MULTI  = 4'h8;
  localparam logic [3:0] SRC_NET    = 4'hB;

  // Digital input function codes
  localparam logic [5:0] FN_EP_UP_A = 6'h0B;
  localparam logic [5:0] FN_EP_UP_B = 6'h21;
  localparam logic [5:0] FN_EP_DN_A = 6'h0C;
  localparam logic [5:0] FN_EP_DN_B = 6'h22;
  localparam logic [5:0] FN_MS_0    = 6'h07;
  localparam logic [5:0] FN_MS_1    = 6'h08;
  localparam logic [5:0] FN_MS_2    = 6'h09;
  localparam logic [7:0] MS_MSB_OK  = 8'h33;

  // Byte addresses of the register words
  localparam logic [7:0] ADR_LIMITS    = 8'h00;
  localparam logic [7:0] ADR_MODE      = 8'h04;
  localparam logic [7:0] ADR_KEYJOG    = 8'h08;
  localparam logic [7:0] ADR_NET       = 8'h0C;
  localparam logic [3:0] ADR_PRESET_HI = 4'h1;
  localparam logic [7:0] ADR_DIFN_A    = 8'h20;
  localparam logic [7:0] ADR_DIFN_B    = 8'h24;
  localparam logic [7:0] ADR_STATUS    = 8'h28;
  localparam logic [7:0] ADR_EPREF     = 8'h2C;

  typedef enum logic [1:0] {
    BK_MIN  = 2'h0,
    BK_LAST = 2'h1,
    BK_KEY  = 2'h2
  } srl_backup_type;

  typedef struct packed {
    logic [6:0] pad_hi;
    logic       remote;
    logic [3:0] remote_sel;
    logic [3:0] local_sel;
    logic       pad_mid;
    logic [6:0] margin;
    logic [5:0] pad_lo;
    logic [1:0] backup;
  } srl_mode_word_type;

  typedef struct packed {
    logic [12:0] pad;
    logic        rev;
    logic        config_incompatible_state;
    logic        fault;
    logic [15:0] mag;
  } srl_stat_word_type;

  typedef struct packed {
    logic [15:0]       min;
    logic [15:0]       max;
    logic [6:0]        margin;
    logic [1:0]        backup;
    logic [3:0]        local_sel;
    logic [3:0]        remote_sel;
    logic              remote;
    logic [15:0]       keypad;
    logic [15:0]       jog;
    logic [15:0]       rated;
    logic [15:0]       net_ref;
    logic [7:0][15:0]  preset;
    logic [7:0][5:0]   di_func;
  } srl_cfg_type;

  typedef struct packed {
    srl_cfg_type           cfg;
    logic                  ack;
    logic [31:0]           dat;
    logic [7:0]            s1;
    logic [7:0]            s2;
    logic [7:0]            s3;
    logic [7:0]            di;
    logic                  en_q;
    logic [15:0]           ep;
    logic [EP_CNT_W-1:0]   ep_cnt;
    logic [OVS_CNT_W-1:0]  ovs_cnt;
    logic                  fault;
    logic                  config_incompatible_state;
    logic                  rev;
    logic [15:0]           ref_mag;
  } srl_state_type;

  localparam srl_cfg_type CFG_RST = '{min: MIN_RST, max: MAX_RST, margin: MARGIN_RST,
                                      backup: BACKUP_RST, local_sel: SRC_KEYPAD,
                                      remote_sel: 4'h1, remote: 1'b0, keypad: KEY_RST,
                                      jog: JOG_RST, rated: RATED_RST, net_ref: 16'h0000,
                                      preset: PRESET_RST, di_func: 48'h0};

  localparam srl_state_type STATE_RST = '{cfg: CFG_RST, ep: KEY_RST, ref_mag: MIN_RST,
                                          default: '0};
endpackage

// ===== rtl/srl_top.sv
// Speed reference limiter: source pick, clamp, backup, presets, e-pot, overspeed
`timescale 1ns/1ns

module srl_top #(
  parameter int unsigned OVS_WAIT_CYCLES = srl_pkg::OVS_CYCLES,
  parameter int unsigned EP_STEP_CYCLES  = srl_pkg::EP_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  di_i,
  input  wire logic        enable_i,
  input  wire logic        jog_i,
  input  wire logic        dir_rev_i,
  input  wire logic        key_up_i,
  input  wire logic        key_dn_i,
  input  wire logic [15:0] speed_meas_i,
  output logic      [15:0] ramp_ref_o,
  output logic             dir_rev_o,
  output logic             pulse_disable_o,
  output logic             overspeed_fault_o,
  output logic             config_incompatible_o
);

  localparam logic [srl_pkg::OVS_CNT_W-1:0] OVS_LAST =
    srl_pkg::OVS_CNT_W'(OVS_WAIT_CYCLES);
  localparam logic [srl_pkg::EP_CNT_W-1:0] EP_LAST =
    srl_pkg::EP_CNT_W'(EP_STEP_CYCLES - 1);

  srl_pkg::srl_state_type     s_r;
  srl_pkg::srl_state_type     s_nxt;
  srl_pkg::srl_mode_word_type wmode;
  srl_pkg::srl_stat_word_type wstat;
  logic [7:0]          up_v;
  logic [7:0]          dn_v;
  logic [7:0]          ms0_v;
  logic [7:0]          ms1_v;
  logic [7:0]          ms2_v;
  logic [7:0]          msb_asg_v;
  logic                inc;
  logic                dec;
  logic                ep_active;
  logic                en_rise;
  logic                multi_msb;
  logic                over;
  logic                wr_go;
  logic                rd_go;
  logic                fault_clr;
  logic [2:0]          ms_idx;
  logic [3:0]          src_sel;
  logic signed [32:0]  net_prod;
  logic signed [15:0]  net_hz;
  logic signed [15:0]  raw_ref;
  logic [22:0]         margin_prod;
  logic [16:0]         ovs_limit;
  logic [15:0]         ref_mag;
  logic                ref_neg;
  logic [31:0]         rd_img;
  logic [31:0]         wdat;

  // Function code decoding, used by every input lane
  function automatic logic srl_is_up(input logic [5:0] f);
    return (f == srl_pkg::FN_EP_UP_A) || (f == srl_pkg::FN_EP_UP_B);
  endfunction

  function automatic logic srl_is_dn(input logic [5:0] f);
    return (f == srl_pkg::FN_EP_DN_A) || (f == srl_pkg::FN_EP_DN_B);
  endfunction

  // Result is never above hi, so a crossed min/max pair still bounds by max
  function automatic logic [15:0] srl_clamp(input logic [15:0] mag, input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] r;
    r = mag;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r;
  endfunction

  // Byte lanes not selected keep the old register content
  function automatic logic [31:0] srl_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Read image of a register word; unmapped words read zero
  function automatic logic [31:0] srl_reg_rd(input srl_pkg::srl_state_type s,
                                             input logic [7:0] a);
    logic [31:0]                r;
    srl_pkg::srl_mode_word_type m;
    srl_pkg::srl_stat_word_type t;
    r = 32'h0;
    m = srl_pkg::srl_mode_word_type'(32'h0);
    t = srl_pkg::srl_stat_word_type'(32'h0);
    m.backup     = s.cfg.backup;
    m.margin     = s.cfg.margin;
    m.local_sel  = s.cfg.local_sel;
    m.remote_sel = s.cfg.remote_sel;
    m.remote     = s.cfg.remote;
    t.mag        = s.ref_mag;
    t.fault      = s.fault;
    t.config_incompatible_state       = s.config_incompatible_state;
    t.rev        = s.rev;
    if (a[7:4] == srl_pkg::ADR_PRESET_HI) begin
      r = {s.cfg.preset[{a[3:2], 1'b1}], s.cfg.preset[{a[3:2], 1'b0}]};
    end else begin
      case (a)
        srl_pkg::ADR_LIMITS: r = {s.cfg.max, s.cfg.min};
        srl_pkg::ADR_MODE:   r = m;
        srl_pkg::ADR_KEYJOG: r = {s.cfg.jog, s.cfg.keypad};
        srl_pkg::ADR_NET:    r = {s.cfg.net_ref, s.cfg.rated};
        srl_pkg::ADR_DIFN_A: begin
          for (int i = 0; i < 4; i++) r[8*i +: 6] = s.cfg.di_func[i];
        end
        srl_pkg::ADR_DIFN_B: begin
          for (int i = 0; i < 4; i++) r[8*i +: 6] = s.cfg.di_func[i+4];
        end
        srl_pkg::ADR_STATUS: r = t;
        srl_pkg::ADR_EPREF:  r = {16'h0000, s.ep};
        default:             r = 32'h0;
      endcase
    end
    return r;
  endfunction

  // Per-input decode of the debounced lanes
  for (genvar g = 0; g < 8; g++) begin : g_di
    assign up_v[g]      = s_r.di[g] && srl_is_up(s_r.cfg.di_func[g]);
    assign dn_v[g]      = s_r.di[g] && srl_is_dn(s_r.cfg.di_func[g]);
    assign ms0_v[g]     = s_r.di[g] && (s_r.cfg.di_func[g] == srl_pkg::FN_MS_0);
    assign ms1_v[g]     = s_r.di[g] && (s_r.cfg.di_func[g] == srl_pkg::FN_MS_1);
    assign msb_asg_v[g] = srl_pkg::MS_MSB_OK[g] && (s_r.cfg.di_func[g] == srl_pkg::FN_MS_2);
    assign ms2_v[g]     = s_r.di[g] && msb_asg_v[g];
  end

  // Shared decode; an active lane means the input is pulled to 0 V
  assign inc       = |up_v;
  assign dec       = |dn_v;
  assign ms_idx    = {|ms2_v, |ms1_v, |ms0_v};
  assign multi_msb = $countones(msb_asg_v) > 1;
  assign src_sel   = s_r.cfg.remote ? s_r.cfg.remote_sel : s_r.cfg.local_sel;
  assign ep_active = (src_sel == srl_pkg::SRC_EP);
  assign en_rise   = enable_i && !s_r.en_q;

  // Network scale to 0.1 Hz: value * rated / 8192
  assign net_prod = $signed(s_r.cfg.net_ref) * $signed({1'b0, s_r.cfg.rated});
  assign net_hz   = net_prod[srl_pkg::NET_SHIFT+15:srl_pkg::NET_SHIFT];

  // Source pick; jog overrides the selected source
  always_comb begin
    raw_ref = 16'sh0000;
    unique case (src_sel)
      srl_pkg::SRC_KEYPAD: raw_ref = $signed(s_r.cfg.keypad);
      srl_pkg::SRC_EP:     raw_ref = $signed(s_r.ep);
      srl_pkg::SRC_MULTI:  raw_ref = $signed(s_r.cfg.preset[ms_idx]);
      srl_pkg::SRC_NET:    raw_ref = net_hz;
      default:             raw_ref = 16'sh0000;
    endcase
    if (jog_i) raw_ref = $signed(s_r.cfg.jog);
  end

  // Magnitude clamp; the sign only steers direction
  assign ref_neg = raw_ref[15];
  assign ref_mag = srl_clamp(ref_neg ? 16'(-raw_ref) : raw_ref,
                             s_r.cfg.min, s_r.cfg.max);

  // Overspeed threshold is max plus a percentage of max
  assign margin_prod = 23'(s_r.cfg.max) * 23'(s_r.cfg.margin);
  assign ovs_limit   = 17'(s_r.cfg.max) + 17'(margin_prod / srl_pkg::PCT_DIV);
  assign over        = (17'(speed_meas_i) > ovs_limit) &&
                       (s_r.cfg.margin < srl_pkg::MARGIN_OFF);

  // Bus strobes: data latched on the request cycle, write lands with ack
  assign rd_go     = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr_go     = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
  assign rd_img    = srl_reg_rd(s_r, wb_adr_i);
  assign wdat      = srl_merge(rd_img, wb_dat_i, wb_sel_i);
  assign wmode     = wdat;
  assign wstat     = wdat;
  assign fault_clr = wr_go && (wb_adr_i == srl_pkg::ADR_STATUS) && wstat.fault;

  // Next-state for the whole block
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    if (rd_go) s_nxt.dat = rd_img;

    // Pin synchroniser; a lane changes only when stages two and three agree
    s_nxt.s1   = di_i;
    s_nxt.s2   = s_r.s1;
    s_nxt.s3   = s_r.s2;
    s_nxt.di   = (s_r.s2 & s_r.s3) | (s_r.di & (s_r.s2 ^ s_r.s3));
    s_nxt.en_q = enable_i;

    // Keypad keys, one step per clock while held, never above max
    if (key_up_i && !key_dn_i) begin
      s_nxt.cfg.keypad = (s_r.cfg.keypad >= s_r.cfg.max) ? s_r.cfg.max
                                                         : s_r.cfg.keypad + 16'h0001;
    end else if (key_dn_i && !key_up_i && (s_r.cfg.keypad != 16'h0000)) begin
      s_nxt.cfg.keypad = s_r.cfg.keypad - 16'h0001;
    end

    // E-pot: reset beats backup restore, restore beats ramping
    if (!enable_i && inc && dec) begin
      s_nxt.ep     = s_r.cfg.min;
      s_nxt.ep_cnt = '0;
    end else if (en_rise) begin
      s_nxt.ep_cnt = '0;
      case (s_r.cfg.backup)
        srl_pkg::BK_MIN: begin
          s_nxt.ep         = s_r.cfg.min;
          s_nxt.cfg.keypad = s_r.cfg.min;
        end
        srl_pkg::BK_KEY: s_nxt.ep = s_r.cfg.keypad;
        default:         s_nxt.ep = s_r.ep;
      endcase
    end else if (ep_active && (inc ^ dec)) begin
      if (s_r.ep_cnt == EP_LAST) begin
        s_nxt.ep_cnt = '0;
        if (inc) begin
          s_nxt.ep = (s_r.ep >= s_r.cfg.max) ? s_r.cfg.max : s_r.ep + 16'h0001;
        end else begin
          s_nxt.ep = (s_r.ep <= s_r.cfg.min) ? s_r.cfg.min : s_r.ep - 16'h0001;
        end
      end else begin
        s_nxt.ep_cnt = s_r.ep_cnt + 1'b1;
      end
    end else begin
      s_nxt.ep_cnt = '0;
    end

    // Overspeed timer; a new trip wins over a clear in the same cycle
    if (over) begin
      if (s_r.ovs_cnt != OVS_LAST) s_nxt.ovs_cnt = s_r.ovs_cnt + 1'b1;
    end else begin
      s_nxt.ovs_cnt = '0;
    end
    s_nxt.fault = (over && (s_r.ovs_cnt == OVS_LAST)) || (s_r.fault && !fault_clr);

    // Output side
    s_nxt.config_incompatible_state    = multi_msb;
    s_nxt.ref_mag = ref_mag;
    s_nxt.rev     = dir_rev_i ^ ref_neg;

    // Software writes, taken at the ack edge
    if (wr_go) begin
      if (wb_adr_i[7:4] == srl_pkg::ADR_PRESET_HI) begin
        s_nxt.cfg.preset[{wb_adr_i[3:2], 1'b0}] = wdat[15:0];
        s_nxt.cfg.preset[{wb_adr_i[3:2], 1'b1}] = wdat[31:16];
      end else begin
        case (wb_adr_i)
          srl_pkg::ADR_LIMITS: {s_nxt.cfg.max, s_nxt.cfg.min} = wdat;
          srl_pkg::ADR_MODE: begin
            s_nxt.cfg.backup     = wmode.backup;
            s_nxt.cfg.margin     = wmode.margin;
            s_nxt.cfg.local_sel  = wmode.local_sel;
            s_nxt.cfg.remote_sel = wmode.remote_sel;
            s_nxt.cfg.remote     = wmode.remote;
          end
          srl_pkg::ADR_KEYJOG: {s_nxt.cfg.jog, s_nxt.cfg.keypad} = wdat;
          srl_pkg::ADR_NET:    {s_nxt.cfg.net_ref, s_nxt.cfg.rated} = wdat;
          srl_pkg::ADR_DIFN_A: begin
            for (int i = 0; i < 4; i++) s_nxt.cfg.di_func[i] = wdat[8*i +: 6];
          end
          srl_pkg::ADR_DIFN_B: begin
            for (int i = 0; i < 4; i++) s_nxt.cfg.di_func[i+4] = wdat[8*i +: 6];
          end
          // Read-only and unmapped words ignore writes, bar the status fault clear; key and restore updates survive
          default: ;
        endcase
      end
    end
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= srl_pkg::STATE_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o              = s_r.ack;
  assign wb_dat_o              = s_r.dat;
  assign ramp_ref_o            = s_r.ref_mag;
  assign dir_rev_o             = s_r.rev;
  assign pulse_disable_o       = s_r.fault;
  assign overspeed_fault_o     = s_r.fault;
  assign config_incompatible_o = s_r.config_incompatible_state;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_en_rise;
    enable_i && !s_r.en_q;
  endsequence

  sequence s_up_step;
    ep_active && inc && !dec && enable_i && s_r.en_q && (s_r.ep_cnt == EP_LAST);
  endsequence

  clamp_range_a: assert property ($stable(s_r.cfg.min) && $stable(s_r.cfg.max) &&
      (s_r.cfg.min <= s_r.cfg.max) |-> (ramp_ref_o >= s_r.cfg.min) &&
      (ramp_ref_o <= s_r.cfg.max))
    else $error("ramp reference outside min/max");

  ovs_trip_a: assert property ($rose(s_r.fault) |-> $past(over) &&
      ($past(s_r.ovs_cnt) == OVS_LAST) && pulse_disable_o)
    else $error("overspeed trip without full wait");

  fault_hold_a: assert property (s_r.fault && !fault_clr |=> s_r.fault)
    else $error("overspeed fault dropped without clear");

  ovs_off_a: assert property ((s_r.cfg.margin >= srl_pkg::MARGIN_OFF) |=>
      !$rose(s_r.fault))
    else $error("overspeed trip while supervision off");

  bk_min_a: assert property (s_en_rise ##0 (s_r.cfg.backup == srl_pkg::BK_MIN) |=>
      (s_r.ep == $past(s_r.cfg.min)))
    else $error("mode 0 enable did not load minimum");

  bk_keep_a: assert property (s_en_rise ##0 (s_r.cfg.backup == srl_pkg::BK_LAST) |=>
      $stable(s_r.ep))
    else $error("mode 1 enable changed reference");

  bk_key_a: assert property (s_en_rise ##0 (s_r.cfg.backup == srl_pkg::BK_KEY) |=>
      (s_r.ep == $past(s_r.cfg.keypad)))
    else $error("mode 2 enable did not load keypad");

  ep_clear_a: assert property (!enable_i && inc && dec |=>
      (s_r.ep == $past(s_r.cfg.min)))
    else $error("e-pot not reset while disabled");

  ep_step_a: assert property (s_up_step ##0 (s_r.ep < s_r.cfg.max) |=>
      (s_r.ep == $past(s_r.ep) + 16'h0001) ##1 (s_r.ep_cnt <= 1))
    else $error("e-pot up step wrong");

  ep_sat_a: assert property (s_up_step ##0 (s_r.ep >= s_r.cfg.max) |=>
      (s_r.ep == $past(s_r.cfg.max)))
    else $error("e-pot passed maximum");

  config_incompatible_state_flag_a: assert property (multi_msb |=> config_incompatible_o)
    else $error("config fault missing");

  wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule // srl_top

// ===== dv/srl_src_model.sv
// Far-side source model: preset code and e-pot keys onto the digital inputs
`timescale 1ns/1ns
module srl_src_model (
  input  wire logic [2:0] ms_code_i,
  input  wire logic       ep_up_i,
  input  wire logic       ep_dn_i,
  output logic      [7:0] di_o
);
  // A pin pulled to 0 V reads as one; code bit 2 sits on the first input
  assign di_o[2:0] = {ms_code_i[0], ms_code_i[1], ms_code_i[2]};
  assign di_o[5:3] = 3'h0;
  // Accelerate and decelerate functions live on the last two pins
  assign di_o[7:6] = {ep_dn_i, ep_up_i};
endmodule // srl_src_model

// ===== dv/tb_speed_reference_limiter.sv
// Self-checking bench for the speed reference limiter
`timescale 1ns/1ns
module tb_speed_reference_limiter;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0, jog = 1'b0, dr = 1'b0;
  logic        ku = 1'b0, kd = 1'b0, up = 1'b0, dn = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [15:0] spd = 16'h0000;
  logic [2:0]  ms = 3'h0;
  logic [7:0]  di;
  logic        ack, dro, pdis, ovf, config_incompatible_state;
  logic [15:0] ramp;
  int          errors = 0;
  int          n_compared = 0;

  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;

  srl_src_model u_src (.ms_code_i(ms), .ep_up_i(up), .ep_dn_i(dn), .di_o(di));

  // Short counts keep the overspeed and e-pot runs brief
  srl_top #(.OVS_WAIT_CYCLES(50), .EP_STEP_CYCLES(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .di_i(di), .enable_i(en), .jog_i(jog), .dir_rev_i(dr),
    .key_up_i(ku), .key_dn_i(kd), .speed_meas_i(spd), .ramp_ref_o(ramp),
    .dir_rev_o(dro), .pulse_disable_o(pdis), .overspeed_fault_o(ovf),
    .config_incompatible_o(config_incompatible_state));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Classic single cycle; request held until the edge where ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    // Ack and read data are the values standing just before this edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1);
    wt(1);
  endtask

  function automatic logic [31:0] md(input logic [1:0] b, input logic [6:0] m,
                                     input logic [3:0] s);
    md = 32'h0010_0000 | {12'h000, s, 1'b0, m, 6'h00, b};
  endfunction

  task automatic t_reset();
    wb(0, 8'h00, 0); chk(q, 32'h0294_001E);
    wb(0, 8'h04, 0); chk(q, md(2'h1, 7'h0A, 4'h0));
    wb(0, 8'h30, 0); chk(q, 32'h0);
    chk(ramp, 16'h001E);
  endtask

  task automatic t_clamp();
    wb(1, 8'h08, 32'h0032_03E8); wt(2); chk(ramp, 16'h0294);
    // Remote side picks an unsupported source: zero reference, lifted to min
    wb(1, 8'h04, md(2'h1, 7'h0A, 4'h0) | 32'h0100_0000); wt(2); chk(ramp, 16'h001E);
    wb(1, 8'h04, md(2'h1, 7'h0A, 4'hB));
    wb(1, 8'h0C, 32'h4000_0258);
    wt(2); chk(ramp, 16'h0294);
    wb(1, 8'h0C, 32'hF800_0258); wt(2); chk({dro, ramp}, 17'h10096);
    @(posedge clk_i) dr <= 1'b1;
    wt(2); chk(dro, 1'b0);
    wb(1, 8'h08, 32'hFFCE_0294);
    @(posedge clk_i) jog <= 1'b1;
    wt(2); chk({dro, ramp}, 17'h00032);
    @(posedge clk_i) begin jog <= 1'b0; dr <= 1'b0; end
    wb(1, 8'h04, md(2'h1, 7'h0A, 4'h0));
    @(posedge clk_i) ku <= 1'b1;
    @(posedge clk_i) ku <= 1'b0;
    wt(2); chk(ramp, 16'h0294);
    @(posedge clk_i) kd <= 1'b1;
    @(posedge clk_i) kd <= 1'b0;
    wt(2); chk(ramp, 16'h0293);
    @(posedge clk_i) ku <= 1'b1;
    @(posedge clk_i) ku <= 1'b0;
    wt(2); chk(ramp, 16'h0294);
  endtask

  task automatic t_preset();
    wb(1, 8'h04, md(2'h1, 7'h0A, 4'h8));
    wb(1, 8'h20, 32'h0007_0809);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i) ms <= k[2:0];
      wt(6); chk(ramp, srl_pkg::PRESET_RST[k]);
    end
    wb(1, 8'h24, 32'h0000_0009); wt(3); chk(config_incompatible_state, 1'b1);
    wb(1, 8'h24, 32'h0C0B_0000); wt(3); chk(config_incompatible_state, 1'b0);
  endtask

  // Stepping, saturation and the disabled double-press reset
  task automatic t_epot();
    wb(1, 8'h04, md(2'h1, 7'h0A, 4'h7));
    @(posedge clk_i) begin en <= 1'b1; up <= 1'b1; end
    // Four edges of input sync, then one step per eight cycles: nine steps by the read
    wt(80); wb(0, 8'h2C, 0); chk(q, 32'h27);
    @(posedge clk_i) begin up <= 1'b0; dn <= 1'b1; end
    wt(200); wb(0, 8'h2C, 0); chk(q, 32'h1E);
    // A low maximum makes the upward run saturate
    wb(1, 8'h00, 32'h0020_001E);
    @(posedge clk_i) begin up <= 1'b1; dn <= 1'b0; end
    wt(60); chk(ramp, 16'h0020);
    wb(0, 8'h2C, 0); chk(q, 32'h20);
    @(posedge clk_i) begin en <= 1'b0; dn <= 1'b1; end
    wt(8); wb(0, 8'h2C, 0); chk(q, 32'h1E);
    @(posedge clk_i) begin up <= 1'b0; dn <= 1'b0; end
    wb(1, 8'h00, 32'h0294_001E);
  endtask

  task automatic reen(input logic [1:0] b);
    wb(1, 8'h04, md(b, 7'h0A, 4'h7));
    @(posedge clk_i) en <= 1'b0;
    @(posedge clk_i) en <= 1'b1;
    wt(3); wb(0, 8'h2C, 0);
  endtask

  task automatic t_backup();
    wb(1, 8'h08, 32'h0032_0064);
    reen(2'h2); chk(q, 32'h64);
    reen(2'h1); chk(q, 32'h64);
    reen(2'h0); chk(q, 32'h1E);
    wb(0, 8'h08, 0); chk(q, 32'h0032_001E);
  endtask

  // Threshold is max plus ten percent: 726
  task automatic t_ovs();
    @(posedge clk_i) spd <= 16'h02D6;
    wt(60); chk({pdis, ovf}, 2'h0);
    @(posedge clk_i) spd <= 16'h02D7;
    wt(45); chk(ovf, 1'b0);
    wt(15); chk({pdis, ovf}, 2'h3);
    @(posedge clk_i) spd <= 16'h0000;
    wb(1, 8'h28, 32'h0001_0000); wt(2); chk({pdis, ovf}, 2'h0);
    wb(1, 8'h04, md(2'h1, 7'h64, 4'h7));
    @(posedge clk_i) spd <= 16'hFFFF;
    wt(80); chk(ovf, 1'b0);
  endtask

  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog at 10,000 cycles, well past the roughly 800 the tests need
  initial begin
    #100_000;
    errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    wt(10);
    @(posedge clk_i) rst_i <= 1'b0;
    wt(1);
    t_reset();
    t_clamp();
    t_preset();
    t_epot();
    t_backup();
    t_ovs();
    wrap_up();
  end
endmodule // tb_speed_reference_limiter
